// ### verilog/watchdog_timer_timed_config.sv
// watchdog timer with fuse-selected safety level and timed change window
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps

// What this block does
// - counter runs on dedicated one-megahertz oscillator
// - restart clears counter, new full period
// - disable or any chip reset clears counter
// - timeout while enabled requests a chip reset
// - select codes pick 16K to 2048K cycles
// - upper three control bits read zero
// - change bit clears itself after four clocks
// - enable sets freely, clears only in window
// - level 1 starts disabled, enable any time
// - prescaler accepted only while window open
// - level 2 always enabled, enable reads one
// - level 2 cannot be disabled at all
// - level 2 second write updates prescaler only
// - timeout gives one-cycle internal reset pulse
// - watchdog reset sets flag, cleared writing zero
module watchdog_timer_timed_config #(
    parameter int unsigned BASE_TIMEOUT_TICKS = wdt_pkg::TIMEOUT_BASE_TICKS,
    parameter int unsigned CNT_W              = 22
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_chip_reset,
    input  wire logic       i_restart,
    input  wire logic       i_always_on_fuse,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wr_data,
    input  wire logic       i_wr_stb,
    input  wire logic       i_rd_stb,
    output logic      [7:0] o_rd_data,
    output logic            o_irq,
    output logic            o_chip_reset_req,
    output logic            o_watchdog_on
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // oscillator cycles of one timeout period for a select code
    function automatic logic [CNT_W-1:0] timeout_ticks(input logic [2:0] sel);
        logic [CNT_W-1:0] base;
        base = CNT_W'(BASE_TIMEOUT_TICKS);
        return base << sel;
    endfunction : timeout_ticks

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic                   tick;
    logic                   fuse_r;
    logic                   fuse_nxt;
    logic                   fuse_valid_r;
    logic                   fuse_valid_nxt;
    logic                   on_r;
    logic                   on_nxt;
    logic [2:0]             sel_r;
    logic [2:0]             sel_nxt;
    wdt_pkg::win_state_t    win_state_r;
    wdt_pkg::win_state_t    win_state_nxt;
    logic [2:0]             win_cnt_r;
    logic [2:0]             win_cnt_nxt;
    logic                   lapse_evt;
    logic                   sel_req;
    logic                   disable_req;
    logic                   pend_clear_r;
    logic                   pend_clear_nxt;
    logic                   pend_sel_r;
    logic                   pend_sel_nxt;
    logic [2:0]             sel_osc_r;
    logic [2:0]             sel_osc_nxt;
    logic [CNT_W-1:0]       cnt_r;
    logic [CNT_W-1:0]       cnt_nxt;
    logic                   fire;
    logic                   clear_req;
    logic                   reset_pulse_r;
    logic                   reset_pulse_nxt;
    logic                   cause_flag_r;
    logic                   cause_flag_nxt;
    logic [wdt_pkg::IRQ_W-1:0] irq_stat_r;
    logic [wdt_pkg::IRQ_W-1:0] irq_stat_nxt;
    logic [wdt_pkg::IRQ_W-1:0] irq_mask_r;
    logic [wdt_pkg::IRQ_W-1:0] irq_mask_nxt;
    logic [wdt_pkg::IRQ_W-1:0] irq_evt;
    logic                   irq_r;
    logic                   irq_nxt;
    logic [7:0]             rd_data_r;
    logic [7:0]             rd_data_nxt;
    logic                   on_out_r;
    logic                   on_out_nxt;
    logic                   chip_rst;
    logic                   eff_on;
    logic                   wr_ctl;
    logic                   wr_cause;
    logic                   wr_stat;
    logic                   wr_mask;
    logic                   wr_win;
    logic                   wr_on;
    logic [2:0]             wr_sel;

    // ------------------------------------------------------------------
    // oscillator enable
    // ------------------------------------------------------------------

    // one pulse per microsecond stands in for the watchdog oscillator
    wdt_osc_tick #(
        .DIV (wdt_pkg::OSC_DIV_CYCLES)
    ) u_osc_tick (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .o_tick    (tick)
    );

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------

    // write strobes per register and fields of the written control byte
    assign wr_ctl   = i_wr_stb && (i_addr == wdt_pkg::ADDR_CONTROL);
    assign wr_cause = i_wr_stb && (i_addr == wdt_pkg::ADDR_RESET_CAUSE);
    assign wr_stat  = i_wr_stb && (i_addr == wdt_pkg::ADDR_IRQ_STATUS);
    assign wr_mask  = i_wr_stb && (i_addr == wdt_pkg::ADDR_IRQ_MASK);
    assign wr_win   = i_wr_data[wdt_pkg::CTL_WIN_BIT];
    assign wr_on    = i_wr_data[wdt_pkg::CTL_ON_BIT];
    assign wr_sel   = i_wr_data[wdt_pkg::CTL_SEL_MSB:wdt_pkg::CTL_SEL_LSB];

    // own timeout pulse and outside chip resets act alike
    assign chip_rst = i_chip_reset || reset_pulse_r;
    assign eff_on   = on_r || fuse_r;

    // ------------------------------------------------------------------
    // configuration and change window
    // ------------------------------------------------------------------

    // fuse capture, enable bit, prescaler and the four-cycle window
    always_comb begin
        fuse_nxt       = fuse_r;
        fuse_valid_nxt = 1'b1;
        on_nxt         = on_r;
        sel_nxt        = sel_r;
        win_state_nxt  = win_state_r;
        win_cnt_nxt    = win_cnt_r;
        lapse_evt      = 1'b0;
        sel_req        = 1'b0;
        // catch the fuse level on the first edge after reset release
        if (!fuse_valid_r) begin
            fuse_nxt = i_always_on_fuse;
        end
        // window closes by itself after four system clocks
        if (win_state_r == wdt_pkg::WIN_OPEN) begin
            if (win_cnt_r == 3'h1) begin
                win_state_nxt = wdt_pkg::WIN_CLOSED;
                win_cnt_nxt   = 3'h0;
                lapse_evt     = 1'b1;
            end else begin
                win_cnt_nxt = win_cnt_r - 3'h1;
            end
        end
        if (wr_ctl) begin
            if (wr_win && wr_on) begin
                // opening write, also enables at level 1
                on_nxt        = 1'b1;
                win_state_nxt = wdt_pkg::WIN_OPEN;
                win_cnt_nxt   = wdt_pkg::CHANGE_WIN_CYCLES;
                lapse_evt     = 1'b0;
            end else if ((win_state_r == wdt_pkg::WIN_OPEN) && !wr_win) begin
                // second write of the timed sequence
                sel_nxt       = wr_sel;
                sel_req       = 1'b1;
                win_state_nxt = wdt_pkg::WIN_CLOSED;
                win_cnt_nxt   = 3'h0;
                lapse_evt     = 1'b0;
                if (!fuse_r) begin
                    on_nxt = wr_on;
                end
            end else if (wr_on) begin
                // enabling needs no sequence; prescaler write ignored
                on_nxt = 1'b1;
            end
        end
        // chip reset clears enable, prescaler and window; a level 2 fuse keeps it on
        if (chip_rst) begin
            on_nxt        = 1'b0;
            sel_nxt       = wdt_pkg::SEL_RST;
            sel_req       = 1'b1;
            win_state_nxt = wdt_pkg::WIN_CLOSED;
            win_cnt_nxt   = 3'h0;
            lapse_evt     = 1'b0;
        end
    end

    // a real disable only happens at level 1
    assign disable_req = on_r && !on_nxt && !fuse_r;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fuse_r       <= 1'b0;
            fuse_valid_r <= 1'b0;
            on_r         <= 1'b0;
            sel_r        <= wdt_pkg::SEL_RST;
            win_state_r  <= wdt_pkg::WIN_CLOSED;
            win_cnt_r    <= 3'h0;
        end else begin
            fuse_r       <= fuse_nxt;
            fuse_valid_r <= fuse_valid_nxt;
            on_r         <= on_nxt;
            sel_r        <= sel_nxt;
            win_state_r  <= win_state_nxt;
            win_cnt_r    <= win_cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // oscillator-timed counter
    // ------------------------------------------------------------------

    // any source that restarts the timeout period
    assign clear_req = i_restart || disable_req || chip_rst;

    // requests wait for the next oscillator pulse; a new request wins
    // over the consumption of an older one so none is lost
    always_comb begin
        pend_clear_nxt  = pend_clear_r;
        pend_sel_nxt    = pend_sel_r;
        sel_osc_nxt     = sel_osc_r;
        cnt_nxt         = cnt_r;
        fire            = 1'b0;
        if (tick) begin
            pend_clear_nxt = 1'b0;
            pend_sel_nxt   = 1'b0;
            if (pend_sel_r || sel_req) begin
                sel_osc_nxt = sel_nxt;
            end
            if (pend_clear_r || clear_req) begin
                cnt_nxt = '0;
            end else if (eff_on) begin
                if (cnt_r == timeout_ticks(sel_osc_r) - CNT_W'(1)) begin
                    cnt_nxt = '0;
                    fire    = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
            end
        end else begin
            if (clear_req) begin
                pend_clear_nxt = 1'b1;
            end
            if (sel_req) begin
                pend_sel_nxt = 1'b1;
            end
        end
        reset_pulse_nxt = fire;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_clear_r  <= 1'b0;
            pend_sel_r    <= 1'b0;
            sel_osc_r     <= wdt_pkg::SEL_RST;
            cnt_r         <= '0;
            reset_pulse_r <= 1'b0;
        end else begin
            pend_clear_r  <= pend_clear_nxt;
            pend_sel_r    <= pend_sel_nxt;
            sel_osc_r     <= sel_osc_nxt;
            cnt_r         <= cnt_nxt;
            reset_pulse_r <= reset_pulse_nxt;
        end
    end

    // ------------------------------------------------------------------
    // status, interrupts and read data
    // ------------------------------------------------------------------

    assign irq_evt = {lapse_evt, reset_pulse_r};

    // sticky flags: hardware set wins over a software clear
    always_comb begin
        cause_flag_nxt = cause_flag_r;
        if (wr_cause && !i_wr_data[wdt_pkg::CAUSE_TIMEOUT_BIT]) begin
            cause_flag_nxt = 1'b0;
        end
        if (reset_pulse_r) begin
            cause_flag_nxt = 1'b1;
        end
        irq_stat_nxt = irq_stat_r;
        if (wr_stat) begin
            irq_stat_nxt = irq_stat_r & ~i_wr_data[wdt_pkg::IRQ_W-1:0];
        end
        irq_stat_nxt = irq_stat_nxt | irq_evt;
        irq_mask_nxt = irq_mask_r;
        if (wr_mask) begin
            irq_mask_nxt = i_wr_data[wdt_pkg::IRQ_W-1:0];
        end
        irq_nxt    = |(irq_stat_nxt & irq_mask_nxt);
        on_out_nxt = on_nxt || fuse_nxt;
        // read data stand only in the cycle after the strobe
        rd_data_nxt = 8'h00;
        if (i_rd_stb) begin
            case (i_addr)
                wdt_pkg::ADDR_CONTROL: begin
                    rd_data_nxt[wdt_pkg::CTL_SEL_MSB:wdt_pkg::CTL_SEL_LSB] = sel_r;
                    rd_data_nxt[wdt_pkg::CTL_ON_BIT]  = eff_on;
                    rd_data_nxt[wdt_pkg::CTL_WIN_BIT] =
                        (win_state_r == wdt_pkg::WIN_OPEN);
                end
                wdt_pkg::ADDR_RESET_CAUSE: begin
                    rd_data_nxt[wdt_pkg::CAUSE_TIMEOUT_BIT] = cause_flag_r;
                end
                wdt_pkg::ADDR_IRQ_STATUS: begin
                    rd_data_nxt[wdt_pkg::IRQ_W-1:0] = irq_stat_r;
                end
                wdt_pkg::ADDR_IRQ_MASK: begin
                    rd_data_nxt[wdt_pkg::IRQ_W-1:0] = irq_mask_r;
                end
                default: begin
                    rd_data_nxt = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cause_flag_r <= 1'b0;
            irq_stat_r   <= '0;
            irq_mask_r   <= wdt_pkg::IRQ_MASK_RST;
            irq_r        <= 1'b0;
            rd_data_r    <= 8'h00;
            on_out_r     <= 1'b0;
        end else begin
            cause_flag_r <= cause_flag_nxt;
            irq_stat_r   <= irq_stat_nxt;
            irq_mask_r   <= irq_mask_nxt;
            irq_r        <= irq_nxt;
            rd_data_r    <= rd_data_nxt;
            on_out_r     <= on_out_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign o_rd_data        = rd_data_r;
    assign o_irq            = irq_r;
    assign o_chip_reset_req = reset_pulse_r;
    assign o_watchdog_on    = on_out_r;

endmodule : watchdog_timer_timed_config

// ### verilog/wdt_pkg.sv
// shared constants and types of the watchdog timer
package wdt_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL     = 8'h00;
    localparam logic [7:0] ADDR_RESET_CAUSE = 8'h01;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h02;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h03;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CTL_SEL_LSB       = 0;   // timeout_sel_0..2
    localparam int CTL_SEL_MSB       = 2;
    localparam int CTL_ON_BIT        = 3;   // watchdog_on
    localparam int CTL_WIN_BIT       = 4;   // change_window_open
    localparam int CAUSE_TIMEOUT_BIT = 3;   // timeout_reset_flag
    localparam int IRQ_TIMEOUT_BIT   = 0;   // watchdog fired
    localparam int IRQ_LAPSE_BIT     = 1;   // window closed unused
    localparam int IRQ_W             = 2;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [2:0]       SEL_RST      = 3'h0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned SYS_CLK_PERIOD_PS = 4000;       // 250 MHz
    localparam int unsigned OSC_FREQ_HZ       = 1000000;    // watchdog oscillator
    localparam int unsigned OSC_PERIOD_PS     = 1000000000 / (OSC_FREQ_HZ / 1000);
    localparam int unsigned OSC_DIV_CYCLES    = OSC_PERIOD_PS / SYS_CLK_PERIOD_PS;
    localparam logic [2:0]  CHANGE_WIN_CYCLES = 3'h4;       // system clocks
    localparam int unsigned TIMEOUT_BASE_TICKS = 16384;     // code 000

    // ------------------------------------------------------------------
    // change window state
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        WIN_CLOSED = 1'b0,
        WIN_OPEN   = 1'b1
    } win_state_t;

endpackage : wdt_pkg

// ### verilog/wdt_osc_tick.sv
// divider that stands in for the watchdog oscillator as an enable pulse
`timescale 1ns/100ps
module wdt_osc_tick #(
    parameter int unsigned DIV = wdt_pkg::OSC_DIV_CYCLES
) (
    input  wire logic i_sys_clk,
    input  wire logic i_rst_n,
    output logic      o_tick
);

    logic [15:0] div_r;
    logic [15:0] div_nxt;
    logic        tick_r;
    logic        tick_nxt;

    // count system clocks, one pulse per oscillator period
    always_comb begin
        tick_nxt = 1'b0;
        div_nxt  = div_r + 16'h0001;
        if (div_r == 16'(DIV - 1)) begin
            div_nxt  = 16'h0000;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_r  <= 16'h0000;
            tick_r <= 1'b0;
        end else begin
            div_r  <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign o_tick = tick_r;

endmodule : wdt_osc_tick

// ### testbench/watchdog_timer_timed_config_properties.sv
// port assertions of the watchdog timer and their bind
`timescale 1ns/100ps
module wdt_port_checker (
    input wire logic       i_sys_clk,
    input wire logic       i_rst_n,
    input wire logic       i_chip_reset,
    input wire logic       i_restart,
    input wire logic       i_always_on_fuse,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic       i_wr_stb,
    input wire logic       i_rd_stb,
    input wire logic [7:0] o_rd_data,
    input wire logic       o_irq,
    input wire logic       o_chip_reset_req,
    input wire logic       o_watchdog_on
);
    // ------------------------------------------------------------------
    // helper ages
    // ------------------------------------------------------------------
    logic [1:0] rst_age_r;
    logic [2:0] open_age_r;
    logic [2:0] req_age_r;
    logic       on_wr;
    logic       ctl_rd;

    assign on_wr = i_wr_stb && i_addr == wdt_pkg::ADDR_CONTROL && i_wr_data[3];

    // cycles since reset release, opening write and last request
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_age_r  <= 2'h0;
            open_age_r <= 3'h7;
            req_age_r  <= 3'h7;
            ctl_rd     <= 1'b0;
        end else begin
            ctl_rd     <= i_rd_stb && i_addr == wdt_pkg::ADDR_CONTROL;
            rst_age_r  <= rst_age_r + {1'b0, rst_age_r != 2'h3};
            open_age_r <= open_age_r + {2'h0, open_age_r != 3'h7};
            req_age_r  <= req_age_r + {2'h0, req_age_r != 3'h7};
            if (on_wr && i_wr_data[4]) begin
                open_age_r <= 3'h0;
            end
            if (o_chip_reset_req) begin
                req_age_r <= 3'h0;
            end
        end
    end

    default clocking dc @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    rd_idle_zero_a: assert property (
        !$past(i_rd_stb) |-> o_rd_data == 8'h00) else $error("read data not idle");
    ctl_reserved_zero_a: assert property (
        ctl_rd |-> o_rd_data[7:5] == 3'h0) else $error("reserved bits set");
    unmapped_zero_a: assert property (
        $past(i_rd_stb) && $past(i_addr) > wdt_pkg::ADDR_IRQ_MASK |-> o_rd_data == 8'h00)
        else $error("unmapped read nonzero");
    req_pulse_a: assert property (
        o_chip_reset_req |=> !o_chip_reset_req) else $error("request longer than one cycle");
    req_needs_on_a: assert property (
        $rose(o_chip_reset_req) |-> $past(o_watchdog_on)) else $error("request while off");
    level2_on_a: assert property (
        i_always_on_fuse && rst_age_r == 2'h3 |-> o_watchdog_on) else $error("level 2 off");
    level2_reads_one_a: assert property (
        ctl_rd && i_always_on_fuse && rst_age_r == 2'h3 |-> o_rd_data[3])
        else $error("level 2 enable reads zero");
    win_close_a: assert property (
        ctl_rd && open_age_r > 3'h4 |-> !o_rd_data[4]) else $error("window still open");
    on_rise_cause_a: assert property (
        $rose(o_watchdog_on) |-> i_always_on_fuse || $past(on_wr) || $past(on_wr, 2))
        else $error("enable rose without cause");
    on_fall_cause_a: assert property (
        $fell(o_watchdog_on) |-> $past(i_chip_reset) || $past(i_chip_reset, 2)
        || req_age_r < 3'h4 || open_age_r < 3'h7) else $error("enable fell without cause");
endmodule : wdt_port_checker

bind watchdog_timer_timed_config wdt_port_checker u_port_checker (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_chip_reset(i_chip_reset),
    .i_restart(i_restart), .i_always_on_fuse(i_always_on_fuse), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
    .o_rd_data(o_rd_data), .o_irq(o_irq), .o_chip_reset_req(o_chip_reset_req),
    .o_watchdog_on(o_watchdog_on)
);

// ### testbench/watchdog_timer_timed_config_bench.sv
// self-checking bench of the watchdog timer
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t value mismatch", $time); end end
module watchdog_timer_timed_config_bench;
    // ------------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------------
    localparam int BASE = 4;
    localparam int DIV  = wdt_pkg::OSC_DIV_CYCLES;
    typedef struct packed {
        logic [1:0] k;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } row_t;
    logic       i_sys_clk;
    logic       i_rst_n;
    logic       i_chip_reset;
    logic       i_restart;
    logic       i_always_on_fuse;
    logic [7:0] i_addr;
    logic [7:0] i_wr_data;
    logic       i_wr_stb;
    logic       i_rd_stb;
    logic [7:0] o_rd_data;
    logic       o_irq;
    logic       o_chip_reset_req;
    logic       o_watchdog_on;
    int         failures;
    int         total_checks;
    int         n;
    int         lo;
    int         hi;
    // kind 0 idle, 1 write, 2 read with expected data
    row_t rows [0:19] = '{
        '{2'h2, 8'h00, 8'h00, 8'h00}, '{2'h2, 8'h01, 8'h00, 8'h00},
        '{2'h2, 8'h03, 8'h00, 8'h00}, '{2'h2, 8'h04, 8'h00, 8'h00},
        '{2'h1, 8'h00, 8'h08, 8'h00}, '{2'h2, 8'h00, 8'h00, 8'h08},
        '{2'h1, 8'h00, 8'h00, 8'h00}, '{2'h1, 8'h00, 8'hE5, 8'h00},
        '{2'h2, 8'h00, 8'h00, 8'h08}, '{2'h1, 8'h00, 8'h18, 8'h00},
        '{2'h2, 8'h00, 8'h00, 8'h18}, '{2'h1, 8'h00, 8'h02, 8'h00},
        '{2'h2, 8'h00, 8'h00, 8'h02}, '{2'h1, 8'h03, 8'h01, 8'h00},
        '{2'h1, 8'h00, 8'h18, 8'h00}, '{2'h0, 8'h00, 8'h00, 8'h00},
        '{2'h0, 8'h00, 8'h00, 8'h00}, '{2'h1, 8'h00, 8'h03, 8'h00},
        '{2'h2, 8'h00, 8'h00, 8'h0A}, '{2'h2, 8'h02, 8'h00, 8'h02}
    };

    watchdog_timer_timed_config #(.BASE_TIMEOUT_TICKS(BASE)) u_watchdog_timer_timed_config (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_chip_reset(i_chip_reset),
        .i_restart(i_restart), .i_always_on_fuse(i_always_on_fuse), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
        .o_rd_data(o_rd_data), .o_irq(o_irq), .o_chip_reset_req(o_chip_reset_req),
        .o_watchdog_on(o_watchdog_on)
    );

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    // one bus cycle, then the data cycle of a read
    task automatic op(input row_t r);
        @(posedge i_sys_clk);
        i_wr_stb  <= (r.k == 2'h1);
        i_rd_stb  <= (r.k == 2'h2);
        i_addr    <= r.a;
        i_wr_data <= r.d;
        @(posedge i_sys_clk);
        i_wr_stb  <= 1'b0;
        i_rd_stb  <= 1'b0;
        #1;
        if (r.k == 2'h2) `CHK(o_rd_data, r.e)
    endtask : op

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        op({2'h1, a, d, 8'h00});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        op({2'h2, a, 8'h00, e});
    endtask : rd

    task automatic settle(input int c);
        repeat (c) @(posedge i_sys_clk);
        #1;
    endtask : settle

    task automatic restart();
        @(posedge i_sys_clk);
        i_restart <= 1'b1;
        @(posedge i_sys_clk);
        i_restart <= 1'b0;
    endtask : restart

    // cycles until the reset request, bounded
    task automatic wait_req(output int cnt);
        cnt = 0;
        do begin
            settle(1);
            cnt++;
        end while (o_chip_reset_req !== 1'b1 && cnt < 40000);
        if (cnt >= 40000) begin
            failures++;
            $display("[ERR] %0t no reset request", $time);
            complete_run();
        end
    endtask : wait_req

    // ------------------------------------------------------------------
    // clock, guard and sequence
    // ------------------------------------------------------------------
    initial begin
        i_sys_clk = 1'b0;
        forever #2 i_sys_clk = ~i_sys_clk;
    end

    initial begin
        repeat (60000) @(posedge i_sys_clk);
        failures++;
        $display("[ERR] %0t run too long", $time);
        complete_run();
    end

    initial begin
        {i_rst_n, i_chip_reset, i_restart, i_always_on_fuse} = 4'h0;
        {i_addr, i_wr_data, i_wr_stb, i_rd_stb} = 18'h0;
        failures = 0;
        total_checks = 0;
        repeat (20) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        foreach (rows[i]) op(rows[i]);
        $display("register table done");
        `CHK(o_irq, 1'b0)
        wr(wdt_pkg::ADDR_IRQ_MASK, 8'h02);
        settle(2);
        `CHK(o_irq, 1'b1)
        wr(wdt_pkg::ADDR_IRQ_STATUS, 8'h02);
        settle(2);
        `CHK(o_irq, 1'b0)
        $display("interrupt done");
        // timed change of select, restarts hold off the first timeout
        for (int s = 0; s < 5; s++) begin
            wr(8'h00, 8'h18);
            wr(8'h00, 8'h08 | 8'(s));
            restart();
            if (s == 0) repeat (4) begin
                repeat (DIV) @(posedge i_sys_clk);
                restart();
            end
            wait_req(n);
            // clear lands on the next oscillator pulse, then a full period
            lo = (BASE << s) * DIV;
            hi = lo + DIV;
            `CHK((n >= lo && n <= hi), 1'b1)
            settle(3);
            `CHK(o_watchdog_on, 1'b0)
            $display("timeout select %0d done", s);
        end
        rd(wdt_pkg::ADDR_RESET_CAUSE, 8'h08);
        wr(wdt_pkg::ADDR_RESET_CAUSE, 8'h00);
        rd(wdt_pkg::ADDR_RESET_CAUSE, 8'h00);
        rd(wdt_pkg::ADDR_IRQ_STATUS, 8'h01);
        wr(8'h00, 8'h08);
        settle(2);
        `CHK(o_watchdog_on, 1'b1)
        @(posedge i_sys_clk);
        i_chip_reset <= 1'b1;
        @(posedge i_sys_clk);
        i_chip_reset <= 1'b0;
        settle(3);
        `CHK(o_watchdog_on, 1'b0)
        rd(8'h00, 8'h00);
        $display("chip reset done");
        // second reset with the fuse programmed
        @(posedge i_sys_clk);
        i_rst_n <= 1'b0;
        i_always_on_fuse <= 1'b1;
        repeat (20) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        settle(3);
        `CHK(o_watchdog_on, 1'b1)
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h08);
        wr(8'h00, 8'h18);
        wr(8'h00, 8'h05);
        rd(8'h00, 8'h0D);
        `CHK(o_watchdog_on, 1'b1)
        $display("always on level done");
        complete_run();
    end
endmodule : watchdog_timer_timed_config_bench
